/* hdl/irq_period_ctrl.sv */
// interrupt control, edge detect and period timer with axi4-lite registers
`timescale 1ns/1ps
`include "irq_period_cfg.svh"

// Contract
// - first register: flags 6..4, enables 3..0
// - second register: flags 6..4, enables 2..0
// - events set flags regardless of enable
// - jump needs global, source enable, flag
// - take: push next pc, load vector
// - return pops saved pc and resumes
// - servicing clears global enable
// - flags held while globally disabled
// - pin, period, timer flags auto-cleared
// - stack full blocks acknowledge
// - any newly set flag wakes device
// - own vectors plus shared multi vector
// - pin flag on selected edge type
// - pull-high kept in interrupt use
// - period divider 1024..8192 sets flag
// - period clock chosen outside block
// - timer overflow sets timer flag
// - edge codes off, rise, fall, both
// - two-wire flag on timeout, match, byte
// - eeprom flag on write end
// - return-from-irq sets global enable
module irq_period_ctrl #(
  parameter int PC_W = 13
) (
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  // axi4-lite slave
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // event sources
  input  wire logic            pin_irq_in,
  input  wire logic            pin_pullup_sel,
  output logic                 pin_pullup_en,
  input  wire logic            touch_event,
  input  wire logic            timer_overflow,
  input  wire logic            eeprom_write_done,
  input  wire logic            serial_event,
  input  wire logic            twowire_timeout,
  input  wire logic            twowire_addr_match,
  input  wire logic            twowire_byte_done,
  input  wire logic            period_src_clock,
  // core sequencer
  input  wire logic            core_fetch_ok,
  input  wire logic [PC_W-1:0] core_next_pc,
  input  wire logic            stack_full,
  input  wire logic            return_from_irq,
  input  wire logic            return_plain,
  input  wire logic [PC_W-1:0] stack_top_pc,
  output logic                 stack_push,
  output logic [PC_W-1:0]      stack_push_pc,
  output logic                 stack_pop,
  output logic                 pc_load,
  output logic [PC_W-1:0]      pc_load_value,
  output logic                 wake_up
);

  // ============================================================
  // vector address from vector number
  function automatic logic [PC_W-1:0] vec_addr(input logic [PC_W-1:0] base,
                                               input logic [2:0] num);
    vec_addr = base + PC_W'({num, 2'b00});
  endfunction

  // ============================================================
  // registers
  logic [7:0]                  ctrl_a_reg;
  logic [7:0]                  ctrl_b_reg;
  logic [1:0]                  edge_reg;
  logic [1:0]                  period_sel_reg;
  logic [PC_W-1:0]             vec_base_reg;
  irq_period_pkg::seq_state_t  seq_reg;
  logic [2:0]                  take_vec_reg;
  logic [PC_W-1:0]             take_pc_reg;

  // ============================================================
  // pin synchronisers
  logic [1:0] pin_sync_reg;
  logic [1:0] psrc_sync_reg;
  logic       pin_last_reg;
  logic       psrc_last_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_sync_reg  <= 2'b00;
      psrc_sync_reg <= 2'b00;
      pin_last_reg  <= 1'b0;
      psrc_last_reg <= 1'b0;
    end else begin
      pin_sync_reg  <= {pin_sync_reg[0], pin_irq_in};
      psrc_sync_reg <= {psrc_sync_reg[0], period_src_clock};
      pin_last_reg  <= pin_sync_reg[1];
      psrc_last_reg <= psrc_sync_reg[1];
    end
  end

  assign pin_pullup_en = pin_pullup_sel;

  logic pin_rise;
  logic pin_fall;
  logic pin_event;
  assign pin_rise = pin_sync_reg[1] & ~pin_last_reg;
  assign pin_fall = ~pin_sync_reg[1] & pin_last_reg;
  always_comb begin
    case (edge_reg)
      `EDGE_RISE: pin_event = pin_rise;
      `EDGE_FALL: pin_event = pin_fall;
      `EDGE_BOTH: pin_event = pin_rise | pin_fall;
      default:    pin_event = 1'b0;
    endcase
  end

  // ============================================================
  // period timer, source clock muxed outside, sampled here
  logic        psrc_tick;
  logic [13:0] period_cnt_reg;
  logic [13:0] period_top;
  logic        period_event;
  assign psrc_tick = psrc_sync_reg[1] & ~psrc_last_reg;

  always_comb begin
    case (period_sel_reg)
      2'b00:   period_top = `PERIOD_DIV_1024;
      2'b01:   period_top = `PERIOD_DIV_2048;
      2'b10:   period_top = `PERIOD_DIV_4096;
      default: period_top = `PERIOD_DIV_8192;
    endcase
  end
  assign period_event = psrc_tick && (period_cnt_reg >= period_top);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      period_cnt_reg <= 14'h0000;
    end else if (psrc_tick) begin
      period_cnt_reg <= period_event ? 14'h0000 : period_cnt_reg + 14'h0001;
    end
  end

  // ============================================================
  // axi4-lite handshakes
  logic       aw_held_reg;
  logic       w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       wr_go;
  logic       wr_a;
  logic       wr_b;
  logic       wr_e;
  logic       wr_p;
  logic       wr_v;
  logic       wr_hit;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_go  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_a   = wr_go && aw_addr_reg == `OFS_IRQ_CTRL_A && w_strb_reg[0];
  assign wr_b   = wr_go && aw_addr_reg == `OFS_IRQ_CTRL_B && w_strb_reg[0];
  assign wr_e   = wr_go && aw_addr_reg == `OFS_EDGE_CTRL && w_strb_reg[0];
  assign wr_p   = wr_go && aw_addr_reg == `OFS_PERIOD_CTRL && w_strb_reg[0];
  assign wr_v   = wr_go && aw_addr_reg == `OFS_VECTOR_BASE;
  assign wr_hit = aw_addr_reg == `OFS_IRQ_CTRL_A || aw_addr_reg == `OFS_IRQ_CTRL_B ||
                  aw_addr_reg == `OFS_EDGE_CTRL || aw_addr_reg == `OFS_PERIOD_CTRL ||
                  aw_addr_reg == `OFS_VECTOR_BASE || aw_addr_reg == `OFS_CORE_STATUS;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `OFS_IRQ_CTRL_A:  s_axi_rdata <= {24'h000000, ctrl_a_reg & `A_MASK};
        `OFS_IRQ_CTRL_B:  s_axi_rdata <= {24'h000000, ctrl_b_reg & `B_MASK};
        `OFS_EDGE_CTRL:   s_axi_rdata <= {30'h00000000, edge_reg};
        `OFS_PERIOD_CTRL: s_axi_rdata <= {26'h0000000, period_sel_reg, 4'h0};
        `OFS_CORE_STATUS: s_axi_rdata <= {26'h0000000, stack_full, seq_reg, take_vec_reg[1:0]};
        `OFS_VECTOR_BASE: s_axi_rdata <= {{(32-PC_W){1'b0}}, vec_base_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // priority arbitration
  logic       req_pin;
  logic       req_touch;
  logic       req_timer;
  logic       req_eeprom;
  logic       req_period;
  logic       req_serial;
  logic       any_req;
  logic       take;
  logic [2:0] pick_vec;
  logic       pick_pin;
  logic       pick_timer;
  logic       pick_touch;
  logic       pick_serial;
  logic       pick_period;
  logic       pick_eeprom;

  assign req_pin    = ctrl_a_reg[`A_PIN_FLAG] & ctrl_a_reg[`A_PIN_EN];
  assign req_touch  = ctrl_a_reg[`A_TOUCH_FLAG] & ctrl_a_reg[`A_TOUCH_EN];
  assign req_timer  = ctrl_a_reg[`A_TIMER_FLAG] & ctrl_a_reg[`A_TIMER_EN];
  assign req_serial = ctrl_b_reg[`B_SERIAL_FLAG] & ctrl_b_reg[`B_SERIAL_EN];
  assign req_period = ctrl_b_reg[`B_PERIOD_FLAG] & ctrl_b_reg[`B_PERIOD_EN];
  assign req_eeprom = ctrl_b_reg[`B_EEPROM_FLAG] & ctrl_b_reg[`B_EEPROM_EN];
  assign any_req = req_pin | req_touch | req_timer | req_serial | req_period | req_eeprom;
  assign take = ctrl_a_reg[`A_GLOBAL_EN] && any_req && !stack_full && core_fetch_ok &&
                seq_reg == irq_period_pkg::seq_idle_s;

  assign pick_pin    = req_pin;
  assign pick_touch  = !pick_pin && req_touch;
  assign pick_timer  = !pick_pin && !req_touch && req_timer;
  assign pick_serial = !pick_pin && !req_touch && !req_timer && req_serial;
  assign pick_period = !pick_pin && !req_touch && !req_timer && !req_serial && req_period;
  assign pick_eeprom = !pick_pin && !req_touch && !req_timer && !req_serial && !req_period;
  assign pick_vec = pick_pin ? `VEC_PIN : pick_touch ? `VEC_TOUCH :
                    pick_timer ? `VEC_TIMER : `VEC_MULTI;

  // ============================================================
  // flag and enable registers, hardware set wins over clear
  logic [7:0] a_next;
  logic [7:0] b_next;
  logic [7:0] a_set;
  logic [7:0] b_set;
  logic [7:0] a_clr;
  logic [7:0] b_clr;

  always_comb begin
    a_set = 8'h00;
    b_set = 8'h00;
    a_clr = 8'h00;
    b_clr = 8'h00;
    a_set[`A_PIN_FLAG]    = pin_event;
    a_set[`A_TOUCH_FLAG]  = touch_event;
    a_set[`A_TIMER_FLAG]  = timer_overflow;
    b_set[`B_SERIAL_FLAG] = serial_event | twowire_timeout | twowire_addr_match |
                            twowire_byte_done;
    b_set[`B_PERIOD_FLAG] = period_event;
    b_set[`B_EEPROM_FLAG] = eeprom_write_done;
    a_set[`A_GLOBAL_EN]   = return_from_irq;
    if (take) begin
      a_clr[`A_GLOBAL_EN]   = 1'b1;
      a_clr[`A_PIN_FLAG]    = pick_pin;
      a_clr[`A_TOUCH_FLAG]  = pick_touch;
      a_clr[`A_TIMER_FLAG]  = pick_timer;
      b_clr[`B_SERIAL_FLAG] = pick_serial;
      b_clr[`B_PERIOD_FLAG] = pick_period;
      b_clr[`B_EEPROM_FLAG] = pick_eeprom;
    end
    a_next = wr_a ? w_data_reg[7:0] & `A_MASK : ctrl_a_reg;
    b_next = wr_b ? w_data_reg[7:0] & `B_MASK : ctrl_b_reg;
    a_next = (a_next & ~a_clr) | a_set;
    b_next = (b_next & ~b_clr) | b_set;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_a_reg <= `CTRL_RESET;
      ctrl_b_reg <= `CTRL_RESET;
    end else begin
      ctrl_a_reg <= a_next;
      ctrl_b_reg <= b_next;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      edge_reg       <= `EDGE_OFF;
      period_sel_reg <= 2'b00;
      vec_base_reg   <= '0;
    end else begin
      if (wr_e) edge_reg <= w_data_reg[`EDGE_LSB +: 2];
      if (wr_p) period_sel_reg <= w_data_reg[`PERIOD_LSB +: 2];
      if (wr_v) vec_base_reg <= w_data_reg[PC_W-1:0];
    end
  end

  // wake on any low-to-high flag change, enables ignored
  logic [7:0] flag_mask;
  assign flag_mask = `FLAG_MASK;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= |((a_next & ~ctrl_a_reg | b_next & ~ctrl_b_reg) & flag_mask);
    end
  end

  // ============================================================
  // take sequence: push pc, then load vector
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_reg       <= irq_period_pkg::seq_idle_s;
      take_vec_reg  <= 3'h0;
      take_pc_reg   <= '0;
      stack_push    <= 1'b0;
      stack_push_pc <= '0;
      pc_load       <= 1'b0;
      pc_load_value <= '0;
      stack_pop     <= 1'b0;
    end else begin
      stack_push <= 1'b0;
      pc_load    <= 1'b0;
      stack_pop  <= 1'b0;
      case (seq_reg)
        irq_period_pkg::seq_idle_s: begin
          if (take) begin
            seq_reg      <= irq_period_pkg::seq_push_s;
            take_vec_reg <= pick_vec;
            take_pc_reg  <= core_next_pc;
          end else if (return_from_irq || return_plain) begin
            stack_pop     <= 1'b1;
            pc_load       <= 1'b1;
            pc_load_value <= stack_top_pc;
          end
        end
        irq_period_pkg::seq_push_s: begin
          stack_push    <= 1'b1;
          stack_push_pc <= take_pc_reg;
          seq_reg       <= irq_period_pkg::seq_load_s;
        end
        irq_period_pkg::seq_load_s: begin
          pc_load       <= 1'b1;
          pc_load_value <= vec_addr(vec_base_reg, take_vec_reg);
          seq_reg       <= irq_period_pkg::seq_idle_s;
        end
        default: seq_reg <= irq_period_pkg::seq_idle_s;
      endcase
    end
  end

endmodule // irq_period_ctrl

/* hdl/irq_period_cfg.svh */
// register offsets, field positions, reset values and vector numbers
`ifndef IRQ_PERIOD_CFG_SVH
`define IRQ_PERIOD_CFG_SVH

// ============================================================
// register byte offsets
`define OFS_IRQ_CTRL_A      8'h00
`define OFS_IRQ_CTRL_B      8'h04
`define OFS_EDGE_CTRL       8'h08
`define OFS_PERIOD_CTRL     8'h0c
`define OFS_CORE_STATUS     8'h10
`define OFS_VECTOR_BASE     8'h14

// ============================================================
// irq_ctrl_a fields
`define A_TIMER_FLAG        6
`define A_TOUCH_FLAG        5
`define A_PIN_FLAG          4
`define A_TIMER_EN          3
`define A_TOUCH_EN          2
`define A_PIN_EN            1
`define A_GLOBAL_EN         0
`define A_MASK              8'h7f

// ============================================================
// irq_ctrl_b fields
`define B_EEPROM_FLAG       6
`define B_PERIOD_FLAG       5
`define B_SERIAL_FLAG       4
`define B_EEPROM_EN         2
`define B_PERIOD_EN         1
`define B_SERIAL_EN         0
`define B_MASK              8'h77
`define FLAG_MASK           8'h70

// ============================================================
// edge_ctrl and period_ctrl fields
`define EDGE_LSB            0
`define EDGE_OFF            2'b00
`define EDGE_RISE           2'b01
`define EDGE_FALL           2'b10
`define EDGE_BOTH           2'b11
`define PERIOD_LSB          4
`define PERIOD_DIV_1024     14'h03ff
`define PERIOD_DIV_2048     14'h07ff
`define PERIOD_DIV_4096     14'h0fff
`define PERIOD_DIV_8192     14'h1fff

// ============================================================
// reset values and vector numbers
`define CTRL_RESET          8'h00
`define VEC_PIN             3'h1
`define VEC_TOUCH           3'h2
`define VEC_TIMER           3'h3
`define VEC_MULTI           3'h4
`define AXI_OKAY            2'b00
`define AXI_SLVERR          2'b10

`endif

/* hdl/irq_period_pkg.sv */
// types shared by the interrupt controller
package irq_period_pkg;

  typedef enum logic [2:0] {
    seq_idle_s = 3'b001,
    seq_push_s = 3'b010,
    seq_load_s = 3'b100
  } seq_state_t;

endpackage

/* dv/irq_monitor.sv */
// checker bound to the interrupt controller ports
`timescale 1ns/1ps
module irq_monitor #(
  parameter int PC_W = 13
) (
  input wire logic            clk_sys,
  input wire logic            resetn,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic            pin_pullup_sel,
  input wire logic            pin_pullup_en,
  input wire logic [PC_W-1:0] core_next_pc,
  input wire logic            stack_full,
  input wire logic [PC_W-1:0] stack_top_pc,
  input wire logic            stack_push,
  input wire logic [PC_W-1:0] stack_push_pc,
  input wire logic            stack_pop,
  input wire logic            pc_load,
  input wire logic [PC_W-1:0] pc_load_value
);
  // ==========================================
  // sequencer, pull-high and read checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_push_load; stack_push |=> pc_load && !stack_pop; endproperty
  a_push_load: assert property (p_push_load) else $error("no load after push");
  property p_push_pc; stack_push |-> stack_push_pc == $past(core_next_pc, 2); endproperty
  a_push_pc: assert property (p_push_pc) else $error("wrong pc pushed");
  property p_full_block; stack_push |-> !$past(stack_full, 2); endproperty
  a_full_block: assert property (p_full_block) else $error("taken while full");
  property p_single; stack_push |=> !stack_push ##1 !stack_push; endproperty
  a_single: assert property (p_single) else $error("back to back take");
  property p_pop_load; stack_pop |-> pc_load && pc_load_value == $past(stack_top_pc);
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("bad resume pc");
  property p_load_cause; pc_load |-> stack_pop || $past(stack_push); endproperty
  a_load_cause: assert property (p_load_cause) else $error("stray load");
  property p_pullup; pin_pullup_en == pin_pullup_sel; endproperty
  a_pullup: assert property (p_pullup) else $error("pull-high lost");
  property p_read_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_read_once: assert property (p_read_once) else $error("read answered twice");
  property p_pop_alone; stack_pop |-> !stack_push; endproperty
  a_pop_alone: assert property (p_pop_alone) else $error("push with pop");
endmodule // irq_monitor

bind irq_period_ctrl irq_monitor #(.PC_W(PC_W)) u_mon (.clk_sys, .resetn, .s_axi_rvalid,
  .s_axi_rready, .pin_pullup_sel, .pin_pullup_en, .core_next_pc, .stack_full, .stack_top_pc,
  .stack_push, .stack_push_pc, .stack_pop, .pc_load, .pc_load_value);

/* dv/core_model.sv */
// behavioural core program counter and stack
`timescale 1ns/1ps
module core_model #(
  parameter int PC_W  = 13,
  parameter int DEPTH = 2
) (
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire logic            stall,
  input  wire logic            stack_push,
  input  wire logic [PC_W-1:0] stack_push_pc,
  input  wire logic            stack_pop,
  input  wire logic            pc_load,
  input  wire logic [PC_W-1:0] pc_load_value,
  output logic                 core_fetch_ok,
  output logic [PC_W-1:0]      core_next_pc,
  output logic                 stack_full,
  output logic [PC_W-1:0]      stack_top_pc
);
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] stk [DEPTH];
  int              sp;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= '0;
      sp <= 0;
    end else begin
      pc_reg <= pc_load ? pc_load_value : pc_reg + 1'b1;
      if (stack_push) begin
        stk[sp] <= stack_push_pc;
        sp <= sp + 1;
      end
      if (stack_pop) sp <= sp - 1;
    end
  end
  // empty stack shows no stale value
  assign stack_top_pc  = (sp > 0) ? stk[sp-1] : ~pc_reg;
  assign stack_full    = (sp >= DEPTH);
  assign core_next_pc  = pc_reg + 1'b1;
  assign core_fetch_ok = !stall;
endmodule // core_model

/* dv/testbench.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  logic        clk_sys, resetn, stall, s_axi_bready, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        pin_irq_in, pin_pullup_sel, pin_pullup_en, period_src_clock;
  logic        touch_event, timer_overflow, eeprom_write_done, serial_event;
  logic        twowire_timeout, twowire_addr_match, twowire_byte_done;
  logic        core_fetch_ok, stack_full, return_from_irq, return_plain;
  logic        stack_push, stack_pop, pc_load, wake_up;
  logic [12:0] core_next_pc, stack_top_pc, stack_push_pc, pc_load_value, vec;
  logic [6:0]  ev;
  int          n_mismatch, comparisons, wakes, takes, pedges, wake_e, w;
  localparam logic [15:0] EXP [7] = '{16'h2000, 16'h4000, 16'h0040, 16'h0010,
                                     16'h0010, 16'h0010, 16'h0010};
  assign {touch_event, timer_overflow, eeprom_write_done, serial_event,
          twowire_timeout, twowire_addr_match, twowire_byte_done} = ev;
  irq_period_ctrl uut (.*);
  core_model core (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    period_src_clock <= ~period_src_clock;
    if (!period_src_clock) pedges++;
    if (wake_up) begin
      wakes++;
      wake_e = pedges;
    end
    if (pc_load && !stack_pop) begin
      takes++;
      vec = pc_load_value;
    end
  end
  // ==========================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (!s_axi_bvalid) n_mismatch++;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (!s_axi_rvalid) n_mismatch++;
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_d, {24'h0, e})
  endtask
  task automatic pulse(input logic [6:0] v);
    ev <= v;
    @(posedge clk_sys);
    ev <= '0;
    @(posedge clk_sys);
    @(posedge clk_sys);
  endtask
  task automatic wait_take(input int n);
    for (int t = 0; t < 200 && takes < n; t++) @(posedge clk_sys);
    `CHK(takes, n)
  endtask
  task automatic wait_wake();
    int w0;
    w0 = wakes;
    for (int t = 0; t < 40000 && wakes == w0; t++) @(posedge clk_sys);
    if (wakes == w0) n_mismatch++;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
  // ==========================================
  // tests
  initial begin
    {resetn, stall, ev, pin_irq_in, pin_pullup_sel, period_src_clock} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, return_from_irq, return_plain} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) ck(8'(4 * i), 8'h00);
    rd(8'h1c);
    `CHK(rsp, 2'b10)
    wr(8'h1c, 32'h1, 2'b10);
    wr(8'h00, 32'h7e);
    ck(8'h00, 8'h7e);
    wr(8'h04, 32'hff);
    ck(8'h04, 8'h77);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      w = wakes;
      pulse(7'h40 >> i);
      `CHK(wakes - w, 1)
      ck(8'h00, EXP[i][15:8]);
      ck(8'h04, EXP[i][7:0]);
    end
    $display("test events done");
    pin_pullup_sel <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(8'h08, 32'(m));
      wr(8'h00, 32'h2);
      pin_irq_in <= 1'b1;
      repeat (8) @(posedge clk_sys);
      ck(8'h00, {3'b000, m[0], 4'h2});
      wr(8'h00, 32'h2);
      pin_irq_in <= 1'b0;
      repeat (8) @(posedge clk_sys);
      ck(8'h00, {3'b000, m[1], 4'h2});
    end
    $display("test pin edges done");
    wr(8'h14, 32'h100);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    pulse(7'h60);
    wr(8'h00, 32'h6c);
    repeat (10) @(posedge clk_sys);
    `CHK(takes, 0)
    stall <= 1'b1;
    wr(8'h00, 32'h6d);
    repeat (10) @(posedge clk_sys);
    `CHK(takes, 0)
    stall <= 1'b0;
    wait_take(1);
    `CHK(vec, 13'h108)
    ck(8'h00, 8'h4c);
    return_from_irq <= 1'b1;
    @(posedge clk_sys);
    return_from_irq <= 1'b0;
    wait_take(2);
    `CHK(vec, 13'h10c)
    ck(8'h00, 8'h0c);
    wr(8'h04, 32'h04);
    wr(8'h00, 32'h0d);
    pulse(7'h10);
    wait_take(3);
    `CHK(vec, 13'h110)
    wr(8'h04, 32'h05);
    wr(8'h00, 32'h0d);
    pulse(7'h08);
    repeat (20) @(posedge clk_sys);
    `CHK(takes, 3)
    return_plain <= 1'b1;
    @(posedge clk_sys);
    return_plain <= 1'b0;
    wait_take(4);
    `CHK(vec, 13'h110)
    ck(8'h00, 8'h0c);
    ck(8'h10, 8'h24);
    $display("test interrupt flow done");
    wr(8'h00, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(8'h0c, 32'(s << 4));
      wr(8'h04, 32'h0);
      wait_wake();
      w = wake_e;
      wr(8'h04, 32'h0);
      wait_wake();
      `CHK(wake_e - w, 1024 << s)
    end
    $display("test period done");
    print_verdict();
  end
endmodule // testbench
